/* File: port_priority_shutdown.sv */
// Per-channel fast shutdown by priority code, and the port power allocation register.
// Assumes priorities and the multi-bit select come from register logic on clk.
// The cleared status, measurement and class registers live outside; they act on the
// one-cycle turn-off strobes given here.

// Summary of operation
// - Lower 3-bit priority value is more important; 000 highest, 111 lowest.
// - Channels sharing a priority are all turned off by one qualifying code.
// - Shutdown turn-off acts like channel reset but leaves cool-down timers running.
// - Turn-off clears change flags, faults, power status, enables, autoclass, foldback.
// - Turn-off forces the channel two-pair policing threshold to all ones.
// - Turn-off clears voltage, current, resistance and autoclass measurements.
// - Turn-off clears requested, detected, assigned and previous class fields.
// - No history of earlier codes; each code uses current priorities only.
// - A code ending in a one is acted on before its final pulse ends; a code ending in a zero is acted on at that pulse's rising edge.
// - Allocation register holds two 3-bit class caps in bits 6-4 and 2-0.
// - Code less than or equal to channel priority turns it off; larger leaves it.
// - Per-channel priority shutdown works only when the multi-bit select is set.
module port_priority_shutdown #(
    parameter int unsigned NCH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic serialShutdownIn,
    input wire logic multiBitPrioritySelect,
    input wire logic [NCH*shutdown_pkg::CODE_W-1:0] channelShutdownPriority,
    input wire logic [7:0] cmdAddr,
    input wire logic cmdWrite,
    input wire logic cmdRead,
    input wire logic [7:0] cmdWrData,
    output logic [7:0] cmdRdData,
    output logic cmdRdValid,
    output logic [2*shutdown_pkg::CODE_W-1:0] pairClassLimit,
    output logic [NCH-1:0] channelTurnOff,
    output logic [NCH-1:0] policingForce,
    output logic [7:0] policingValue
);

    typedef struct packed {
        logic [7:0] alloc;
        logic [7:0] rdData;
        logic rdValid;
        logic [NCH-1:0] offMask;
        logic [NCH-1:0] police;
    } core_s;

    core_s c_r;
    core_s c_nxt;

    shutdown_code_if codeBus ();

    // ----------------------------------------
    // Serial code receiver
    // ----------------------------------------
    shutdown_code_rx rx (
        .clk(clk),
        .rstn(rstn),
        .serialShutdownIn(serialShutdownIn),
        .codeOut(codeBus)
    );

    // A channel is hit when the code is not above its priority value.
    function automatic logic [NCH-1:0] hitMask(
        input logic [shutdown_pkg::CODE_W-1:0] code,
        input logic [NCH*shutdown_pkg::CODE_W-1:0] prio
    );
        hitMask = '0;
        for (int i = 0; i < NCH; i++)
        begin
            hitMask[i] = code <= prio[i*shutdown_pkg::CODE_W +: shutdown_pkg::CODE_W];
        end
    endfunction

    // ----------------------------------------
    // Shutdown decision and register access
    // ----------------------------------------
    // Strobes are rebuilt from scratch every cycle, so an old code never lingers.
    // Cool-down timers are not told anything here, which is why they keep running.
    always_comb
    begin
        c_nxt = c_r;
        c_nxt.offMask = '0;
        c_nxt.police = '0;
        c_nxt.rdValid = 1'b0;
        if (codeBus.codeValid && multiBitPrioritySelect)
        begin
            c_nxt.offMask = hitMask(codeBus.code, channelShutdownPriority);
            c_nxt.police = c_nxt.offMask;
        end
        if (cmdWrite && cmdAddr == shutdown_pkg::ALLOC_OFFSET)
        begin
            c_nxt.alloc = cmdWrData;
        end
        if (cmdRead)
        begin
            c_nxt.rdValid = 1'b1;
            c_nxt.rdData = (cmdAddr == shutdown_pkg::ALLOC_OFFSET) ? c_r.alloc
                : shutdown_pkg::UNMAPPED_READ;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            c_r <= '{alloc: shutdown_pkg::ALLOC_RESET, default: '0};
        end
        else
        begin
            c_r <= c_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // One strobe clears flags, enables, measurements and class fields of a channel.
    assign channelTurnOff = c_r.offMask;
    assign policingForce = c_r.police;
    assign policingValue = shutdown_pkg::POLICING_FORCE;
    assign pairClassLimit = {c_r.alloc[shutdown_pkg::ALLOC_HI_LSB +: shutdown_pkg::CODE_W],
        c_r.alloc[shutdown_pkg::ALLOC_LO_LSB +: shutdown_pkg::CODE_W]};
    assign cmdRdData = c_r.rdData;
    assign cmdRdValid = c_r.rdValid;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);

    // Independent expectation: a channel stays on only when the code exceeds its priority.
    logic [NCH-1:0] expMask;
    logic [NCH-1:0] prioAllOnes;
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            expMask[i] = !(codeBus.code > channelShutdownPriority[i*3 +: 3]);
            prioAllOnes[i] = &channelShutdownPriority[i*3 +: 3];
        end
    end

    // The code strobe and the two steps of an allocation access, as named sequences.
    sequence codeSeen;
        codeBus.codeValid && multiBitPrioritySelect;
    endsequence

    sequence allocWrite;
        cmdWrite && cmdAddr == shutdown_pkg::ALLOC_OFFSET;
    endsequence

    sequence allocRead;
        cmdRead && !cmdWrite && cmdAddr == shutdown_pkg::ALLOC_OFFSET;
    endsequence

    // Shutdown side: which channels fall, and for how long the strobes stand.
    a_off_matches_code: assert property (codeSeen |=> channelTurnOff == $past(expMask))
        else $error("turn-off strobes do not match the code and priorities");

    a_select_gates_off: assert property (
        codeBus.codeValid && !multiBitPrioritySelect |=> channelTurnOff == '0)
        else $error("turn-off while multi-bit priority is not selected");

    a_off_needs_code: assert property (
        channelTurnOff != '0 |-> $past(codeBus.codeValid && multiBitPrioritySelect))
        else $error("turn-off strobe without a selected code");

    a_code_zero_all: assert property (
        (codeSeen and (codeBus.code == 3'h0)) |=> channelTurnOff == '1)
        else $error("code zero did not turn off every channel");

    a_code_seven_low: assert property (
        (codeSeen and (codeBus.code == 3'h7)) |=> channelTurnOff == $past(prioAllOnes))
        else $error("code seven hit a channel of higher priority");

    a_no_stale_off: assert property (!codeBus.codeValid |=> channelTurnOff == '0)
        else $error("turn-off strobe without a fresh code");

    // Pulses are at least a few cycles apart, so a decoded code never meets its successor.
    a_code_pulse: assert property (codeBus.codeValid |=> !codeBus.codeValid)
        else $error("decoded code held longer than one cycle");

    // A strobe that stood two cycles would clear a channel the host may already restart.
    a_strobe_one_cycle: assert property (channelTurnOff != '0 |=> channelTurnOff == '0)
        else $error("turn-off strobe held longer than one cycle");

    a_police_with_off: assert property (
        channelTurnOff != '0 |-> policingForce == channelTurnOff && policingValue == 8'hFF)
        else $error("policing threshold not forced with the turn-off");

    a_police_quiet: assert property (channelTurnOff == '0 |-> policingForce == '0)
        else $error("policing threshold forced without a turn-off");

    // Register side: the allocation byte, its fields and the read answer.
    a_alloc_write_fields: assert property (
        allocWrite |=> pairClassLimit == {$past(cmdWrData[6:4]), $past(cmdWrData[2:0])})
        else $error("allocation fields not taken from the write");

    // Only a write to the allocation byte may move the class caps.
    a_alloc_holds: assert property (
        !(cmdWrite && cmdAddr == 8'h29) |=> $stable(pairClassLimit))
        else $error("allocation fields changed without a write");

    a_alloc_readback: assert property (
        allocWrite ##1 allocRead |=> cmdRdValid && cmdRdData == $past(cmdWrData, 2))
        else $error("allocation register read back wrong");

    a_read_answer: assert property (cmdRead |=> cmdRdValid)
        else $error("read not answered in the next cycle");

    a_read_quiet: assert property (!cmdRead |=> !cmdRdValid)
        else $error("read answer without a read");

    a_unmapped_read: assert property (
        cmdRead && cmdAddr != 8'h29 |=> cmdRdData == 8'h00)
        else $error("unmapped address did not read as zero");

endmodule

/* File: shutdown_pkg.sv */
// Constants shared by the priority shutdown logic and its serial code receiver.
// Assumes a single 25 MHz clock and an asynchronous active-low reset.
package shutdown_pkg;

    // ----------------------------------------
    // Clock and serial code timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    // A low pulse at least this long carries a one, a shorter one a zero.
    localparam int unsigned ONE_MIN_NS = 1000;
    localparam int unsigned ONE_MIN_CYC = (ONE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Idle time after which a partly received code is thrown away.
    localparam int unsigned GAP_MAX_NS = 50000;
    localparam int unsigned GAP_CYC = GAP_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 11;

    // ----------------------------------------
    // Shutdown code and priority layout
    // ----------------------------------------
    localparam int unsigned CODE_W = 3;
    localparam logic [1:0] LAST_BIT = 2'h2;

    // ----------------------------------------
    // Power allocation register
    // ----------------------------------------
    localparam logic [7:0] ALLOC_OFFSET = 8'h29;
    localparam logic [7:0] ALLOC_RESET = 8'h00;
    localparam int unsigned ALLOC_HI_LSB = 4;
    localparam int unsigned ALLOC_LO_LSB = 0;
    localparam logic [7:0] POLICING_FORCE = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

/* File: shutdown_code_if.sv */
// Carries one decoded shutdown code from the serial receiver to the channel logic.
// Both ends run on the same clock; codeValid is a one-cycle pulse.
interface shutdown_code_if;
    logic codeValid;
    logic [shutdown_pkg::CODE_W-1:0] code;
    modport source (output codeValid, output code);
    modport sink (input codeValid, input code);
endinterface

/* File: shutdown_code_rx.sv */
// Serial shutdown input receiver: three active-low pulses, MSB first, form one code.
// Assumes the input pin is asynchronous to clk and idles high.
module shutdown_code_rx (
    input wire logic clk,
    input wire logic rstn,
    input wire logic serialShutdownIn,
    shutdown_code_if.source codeOut
);

    typedef struct packed {
        logic syncA;
        logic syncB;
        logic prevLvl;
        logic done;
        logic [shutdown_pkg::CNT_W-1:0] width;
        logic [shutdown_pkg::CNT_W-1:0] gap;
        logic [1:0] bitCnt;
        logic [shutdown_pkg::CODE_W-1:0] shift;
        logic valid;
        logic [shutdown_pkg::CODE_W-1:0] code;
    } rx_s;

    rx_s r_r;
    rx_s r_nxt;

    // Saturating increment keeps long idle or long pulses from wrapping.
    function automatic logic [shutdown_pkg::CNT_W-1:0] satInc(
        input logic [shutdown_pkg::CNT_W-1:0] v
    );
        satInc = (v == '1) ? v : v + 1'b1;
    endfunction

    // ----------------------------------------
    // Pulse width decoding
    // ----------------------------------------
    // The final pulse is acted on as soon as it is known to be a one, while it is still low.
    // A short final pulse can only be told apart at its rising edge.
    always_comb
    begin
        r_nxt = r_r;
        r_nxt.syncA = serialShutdownIn;
        r_nxt.syncB = r_r.syncA;
        r_nxt.prevLvl = r_r.syncB;
        r_nxt.valid = 1'b0;
        if (!r_r.syncB)
        begin
            r_nxt.gap = '0;
            r_nxt.width = r_r.prevLvl ? 11'h001 : satInc(r_r.width);
            if (r_r.bitCnt == shutdown_pkg::LAST_BIT && !r_r.done
                && r_nxt.width == 11'(shutdown_pkg::ONE_MIN_CYC))
            begin
                r_nxt.valid = 1'b1;
                r_nxt.code = {r_r.shift[1:0], 1'b1};
                r_nxt.done = 1'b1;
            end
        end
        else if (!r_r.prevLvl)
        begin
            if (r_r.done)
            begin
                r_nxt.done = 1'b0;
                r_nxt.bitCnt = 2'h0;
            end
            else
            begin
                r_nxt.shift = {r_r.shift[1:0], r_r.width >= 11'(shutdown_pkg::ONE_MIN_CYC)};
                if (r_r.bitCnt == shutdown_pkg::LAST_BIT)
                begin
                    r_nxt.valid = 1'b1;
                    r_nxt.code = r_nxt.shift;
                    r_nxt.bitCnt = 2'h0;
                end
                else
                begin
                    r_nxt.bitCnt = r_r.bitCnt + 2'h1;
                end
            end
        end
        else
        begin
            r_nxt.gap = satInc(r_r.gap);
            if (r_r.gap >= 11'(shutdown_pkg::GAP_CYC))
            begin
                r_nxt.bitCnt = 2'h0;
                r_nxt.done = 1'b0;
            end
        end
    end

    // State register; the pin synchroniser starts high to match the idle level.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r_r <= '{syncA: 1'b1, syncB: 1'b1, prevLvl: 1'b1, default: '0};
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    assign codeOut.codeValid = r_r.valid;
    assign codeOut.code = r_r.code;

endmodule

/* File: shutdown_host_model.sv */
// Host model that drives the serial shutdown pin with three-pulse codes.
// Assumes the bench clock and that the pin idles high between codes.
module shutdown_host_model (
    input wire logic clk,
    output logic serialShutdownIn
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Pin driver
    // ----------------------------------------
    // The pin idles high, and every change is made at the falling edge.
    initial serialShutdownIn = 1'b1;

    // A long low pulse carries a one and a short one a zero.
    // Widths sit well clear of the 25-cycle threshold.
    task automatic send_bit(input logic b);
        int n;
        n = b ? 30 : 5;
        @(negedge clk);
        serialShutdownIn = 1'b0;
        repeat (n) @(negedge clk);
        serialShutdownIn = 1'b1;
        repeat (10) @(negedge clk);
    endtask

    // Each group of channels costs one whole code, sent MSB first.
    task automatic send_code(input logic [2:0] c);
        for (int i = 2; i >= 0; i--)
        begin
            send_bit(c[i]);
        end
        repeat (10) @(negedge clk);
    endtask
endmodule

/* File: port_priority_shutdown_bench.sv */
// Self-checking bench for the priority shutdown block and its allocation register.
// Assumes the host model drives the serial pin; all other inputs are driven here.
module port_priority_shutdown_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic serialShutdownIn;
    logic multiBitPrioritySelect = 1'b1;
    logic [23:0] channelShutdownPriority = 24'h00_0000;
    logic [7:0] cmdAddr = 8'h00;
    logic cmdWrite = 1'b0;
    logic cmdRead = 1'b0;
    logic [7:0] cmdWrData = 8'h00;
    logic [7:0] cmdRdData;
    logic cmdRdValid;
    logic [5:0] pairClassLimit;
    logic [7:0] channelTurnOff;
    logic [7:0] policingForce;
    logic [7:0] policingValue;
    logic [7:0] seenMask = 8'h00;
    logic seenLow = 1'b0;
    int failures = 0;
    int samplesChecked = 0;

    // ----------------------------------------
    // Clock, instances and closing report
    // ----------------------------------------
    // The 40 ns clock.
    initial forever #20 clk = ~clk;

    port_priority_shutdown uut (.clk(clk), .rstn(rstn), .serialShutdownIn(serialShutdownIn),
        .multiBitPrioritySelect(multiBitPrioritySelect),
        .channelShutdownPriority(channelShutdownPriority), .cmdAddr(cmdAddr),
        .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdWrData(cmdWrData), .cmdRdData(cmdRdData),
        .cmdRdValid(cmdRdValid), .pairClassLimit(pairClassLimit),
        .channelTurnOff(channelTurnOff), .policingForce(policingForce),
        .policingValue(policingValue));
    shutdown_host_model host (.clk(clk), .serialShutdownIn(serialShutdownIn));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // Strobe monitor
    // ----------------------------------------
    // Collects every turn-off strobe and notes whether one came while the pin was low.
    // The policing load must follow the turn-off strobe cycle for cycle.
    always @(negedge clk)
    begin
        if (channelTurnOff !== 8'h00)
        begin
            seenMask = seenMask | channelTurnOff;
            if (serialShutdownIn === 1'b0)
                seenLow = 1'b1;
            check("policingValue", 8'hFF, policingValue);
        end
        if (policingForce !== channelTurnOff)
            check("policingForce", channelTurnOff, policingForce);
    end

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        cmdAddr = a;
        cmdWrData = d;
        cmdWrite = 1'b1;
        @(negedge clk);
        cmdWrite = 1'b0;
        @(negedge clk);
    endtask

    // The answer stands for one cycle, so it is looked at in that cycle.
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        cmdAddr = a;
        cmdRead = 1'b1;
        @(negedge clk);
        cmdRead = 1'b0;
        check("cmdRdValid", 8'h01, {7'h00, cmdRdValid});
        check("cmdRdData", exp, cmdRdData);
        @(negedge clk);
        check("cmdRdValid low", 8'h00, {7'h00, cmdRdValid});
    endtask

    // Both fields, the reserved bits and an unmapped address.
    task automatic scenario_alloc();
        reg_read(8'h29, 8'h00);
        check("pairClassLimit reset", 8'h00, {2'h0, pairClassLimit});
        reg_write(8'h29, 8'hFF);
        check("pairClassLimit all", 8'h3F, {2'h0, pairClassLimit});
        reg_read(8'h29, 8'hFF);
        reg_write(8'h29, 8'h35);
        check("pairClassLimit split", 8'h1D, {2'h0, pairClassLimit});
        reg_write(8'h2A, 8'h77);
        reg_read(8'h29, 8'h35);
        reg_read(8'h2A, 8'h00);
        // A read right behind a write must already see the new byte.
        cmdAddr = 8'h29;
        cmdWrData = 8'hA6;
        cmdWrite = 1'b1;
        @(negedge clk);
        cmdWrite = 1'b0;
        reg_read(8'h29, 8'hA6);
        check("pairClassLimit back to back", 8'h16, {2'h0, pairClassLimit});
    endtask

    // ----------------------------------------
    // Shutdown scenarios
    // ----------------------------------------
    // Sends one code and compares the channels that were turned off.
    task automatic shut(input logic [2:0] c, input logic [7:0] exp);
        seenMask = 8'h00;
        seenLow = 1'b0;
        host.send_code(c);
        check("turned off channels", exp, seenMask);
        if (c[0] && exp != 8'h00)
            check("strobe before pulse end", 8'h01, {7'h00, seenLow});
    endtask

    // Channel n holds priority n; every code is tried, each on its own.
    task automatic scenario_ladder();
        logic [7:0] exp;
        for (int n = 0; n < 8; n++)
            channelShutdownPriority[3*n +: 3] = 3'(n);
        for (int c = 7; c >= 0; c--)
        begin
            exp = 8'h00;
            for (int n = 0; n < 8; n++)
                exp[n] = (c <= n);
            shut(3'(c), exp);
        end
    endtask

    // Shared settings fall together, and the select bit gates everything.
    task automatic scenario_shared();
        channelShutdownPriority = {3'd3, 3'd1, 3'd1, 3'd5, 3'd5, 3'd3, 3'd3, 3'd3};
        shut(3'd3, 8'h9F);
        shut(3'd4, 8'h18);
        shut(3'd1, 8'hFF);
        multiBitPrioritySelect = 1'b0;
        shut(3'd0, 8'h00);
        multiBitPrioritySelect = 1'b1;
        shut(3'd6, 8'h00);
    endtask

    // Two pulses left idle past the gap time are dropped, so the next code stands alone.
    // Were they kept, code seven would be read as 001 and hit seven channels.
    task automatic scenario_stale();
        channelShutdownPriority = 24'hFA_C688;
        seenMask = 8'h00;
        host.send_bit(1'b0);
        host.send_bit(1'b0);
        repeat (1300) @(negedge clk);
        check("strobes from partial code", 8'h00, seenMask);
        shut(3'd7, 8'h80);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        scenario_alloc();
        scenario_ladder();
        scenario_shared();
        scenario_stale();
        complete_run();
    end
endmodule
